// >>> hw/sffc_regs.vh
// Register addresses, bit positions, codes and timing for the security fuse and flash control.
`ifndef SFFC_REGS_VH
`define SFFC_REGS_VH
`define SFFC_SFR_LO          8'h80
`define SFFC_XSFR_BASE       16'hfc00
`define SFFC_ADDR_FLASH_CTL  8'hb2
`define SFFC_ADDR_BURN_PULSE 16'hffd1
`define SFFC_ADDR_FUSE_SETUP 16'hffd2
`define SFFC_ADDR_SEC_STAT   16'hffd7
`define SFFC_BIT_PWE         0
`define SFFC_BIT_MEEN        1
`define SFFC_BIT_PROTECT     6
`define SFFC_BIT_FUSE_PROG   7
`define SFFC_BIT_PIN         5
`define SFFC_BIT_FUSE1       1
`define SFFC_BIT_FUSE0       0
`define SFFC_CODE_SETUP      8'h54
`define SFFC_CODE_MODE0      8'h81
`define SFFC_CODE_MODE1      8'h82
`define SFFC_CODE_BURN       8'ha6
`define SFFC_RESET_BYTE      8'h00
`define SFFC_UNDEF_BYTE      8'h00
`define SFFC_BURN_US         500
`define SFFC_CLK_MHZ         100
`endif

// >>> hw/sffc_fuse_burner.v
// Fuse-burn sequencer: set-up code, mode select, then timed burn pulse.
`timescale 1ns/10ps
`include "sffc_regs.vh"
module sffc_fuse_burner #(
  parameter BURN_CYCLES = `SFFC_BURN_US * `SFFC_CLK_MHZ
) (
  input  wire       ref_clk,
  input  wire       rst_b,
  input  wire       setup_wr,
  input  wire       pulse_wr,
  input  wire [7:0] wr_data,
  input  wire       prog_enable,
  input  wire       sec_pin,
  output reg        burn0_r,
  output reg        burn1_r,
  output reg        armed_r,
  output reg  [1:0] mode_r,
  output reg        fuse0_done_r,
  output reg        fuse1_done_r
);
  reg [31:0] burn_cnt_r;
  reg        burning;
  always @* burning = burn0_r | burn1_r;

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      armed_r    <= 1'b0;
      mode_r     <= 2'b00;
      burn0_r    <= 1'b0;
      burn1_r    <= 1'b0;
      burn_cnt_r <= 32'h0000_0000;
    end else begin
      if (setup_wr) begin
        if (wr_data == `SFFC_CODE_SETUP) begin
          armed_r <= 1'b1;
          mode_r  <= 2'b00;
        end else if (armed_r && mode_r == 2'b00 && wr_data == `SFFC_CODE_MODE0) begin
          mode_r <= 2'b01;
        end else if (armed_r && mode_r == 2'b00 && wr_data == `SFFC_CODE_MODE1) begin
          mode_r <= 2'b10;
        end else begin
          // Reserved codes disarm so a stray write cannot lead to a burn.
          armed_r <= 1'b0;
          mode_r  <= 2'b00;
        end
      end
      if (pulse_wr) begin
        if (wr_data == `SFFC_CODE_BURN && armed_r && prog_enable && mode_r != 2'b00) begin
          burn0_r <= mode_r[0];
          burn1_r <= mode_r[1];
        end else begin
          burn0_r <= 1'b0;
          burn1_r <= 1'b0;
          if (burning) begin
            armed_r <= 1'b0;
            mode_r  <= 2'b00;
          end
        end
      end
      if (burn1_r && !sec_pin)
        burn1_r <= 1'b0;
      if (burning)
        burn_cnt_r <= burn_cnt_r + 32'h0000_0001;
      else
        burn_cnt_r <= 32'h0000_0000;
    end
  end

  // Fuse model: a blown fuse survives reset in silicon; here only a cold reset is modelled, so
  // the state is cleared by rst_b and must be reloaded from the real fuse cell in a product.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      fuse0_done_r <= 1'b0;
      fuse1_done_r <= 1'b0;
    end else begin
      if (burn0_r && burn_cnt_r >= BURN_CYCLES)
        fuse0_done_r <= 1'b1;
      if (burn1_r && sec_pin && burn_cnt_r >= BURN_CYCLES)
        fuse1_done_r <= 1'b1;
    end
  end
endmodule // sffc_fuse_burner

// >>> hw/sffc_top.v
// Security fuse and flash control register block on the special function register bus.
`timescale 1ns/10ps
`include "sffc_regs.vh"
module sffc_top #(
  parameter BURN_CYCLES = `SFFC_BURN_US * `SFFC_CLK_MHZ
) (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  input  wire [7:0]  sfr_addr,
  input  wire        xsfr_wr,
  input  wire        xsfr_rd,
  input  wire [15:0] xsfr_addr,
  input  wire [7:0]  wr_data,
  input  wire        int_enabled,
  input  wire        flash_byte_written,
  input  wire        mass_erase_done,
  input  wire        sec_pin,
  input  wire        ext_read_req,
  input  wire        page0_write_req,
  input  wire        debug_req,
  input  wire        debug_bulk_erase,
  output reg  [7:0]  rd_data_r,
  output reg         program_write_enable_r,
  output reg         mass_erase_enable_r,
  output reg         code_protect_bit_r,
  output reg         ext_read_block_r,
  output reg         page0_write_block_r,
  output reg         debug_port_block_r,
  output reg         debug_port_off_r,
  output reg         mode0_code_protect_bit_r,
  output reg         burn0_out_r,
  output reg         burn1_out_r
);
  reg        fuse_program_enable_r;
  wire       burn0;
  wire       burn1;
  wire       mode0_fuse_state;
  wire       mode1_fuse_state;

  function is_xaddr;
    input [15:0] a;
    input [15:0] reg_addr;
    begin
      is_xaddr = (a >= `SFFC_XSFR_BASE) && (a == reg_addr);
    end
  endfunction

  wire flash_ctl_wr = sfr_wr && sfr_addr >= `SFFC_SFR_LO && sfr_addr == `SFFC_ADDR_FLASH_CTL;
  wire flash_ctl_rd = sfr_rd && sfr_addr >= `SFFC_SFR_LO && sfr_addr == `SFFC_ADDR_FLASH_CTL;
  wire setup_wr     = xsfr_wr && is_xaddr(xsfr_addr, `SFFC_ADDR_FUSE_SETUP);
  wire pulse_wr     = xsfr_wr && is_xaddr(xsfr_addr, `SFFC_ADDR_BURN_PULSE);
  wire sec_wr       = xsfr_wr && is_xaddr(xsfr_addr, `SFFC_ADDR_SEC_STAT);
  wire sec_rd       = xsfr_rd && is_xaddr(xsfr_addr, `SFFC_ADDR_SEC_STAT);

  sffc_fuse_burner #(
    .BURN_CYCLES (BURN_CYCLES)
  ) u_burner (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .setup_wr     (setup_wr),
    .pulse_wr     (pulse_wr),
    .wr_data      (wr_data),
    .prog_enable  (fuse_program_enable_r),
    .sec_pin      (sec_pin),
    .burn0_r      (burn0),
    .burn1_r      (burn1),
    .armed_r      (),
    .mode_r       (),
    .fuse0_done_r (mode0_fuse_state),
    .fuse1_done_r (mode1_fuse_state)
  );

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      program_write_enable_r <= 1'b0;
      mass_erase_enable_r    <= 1'b0;
      code_protect_bit_r     <= 1'b0;
      fuse_program_enable_r  <= 1'b0;
    end else begin
      if (flash_ctl_wr && !int_enabled)
        program_write_enable_r <= wr_data[`SFFC_BIT_PWE];
      else if (flash_byte_written)
        program_write_enable_r <= 1'b0;
      if (flash_ctl_wr)
        mass_erase_enable_r <= wr_data[`SFFC_BIT_MEEN];
      else if (mass_erase_done)
        mass_erase_enable_r <= 1'b0;
      if (flash_ctl_wr && wr_data[`SFFC_BIT_PROTECT])
        code_protect_bit_r <= 1'b1;
      if (sec_wr)
        fuse_program_enable_r <= wr_data[`SFFC_BIT_FUSE_PROG];
    end
  end

  // Enforcement outputs are registered, so they lag the protect bit by one cycle.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      ext_read_block_r    <= 1'b0;
      page0_write_block_r <= 1'b0;
      debug_port_block_r  <= 1'b0;
      debug_port_off_r    <= 1'b0;
      mode0_code_protect_bit_r      <= 1'b0;
      burn0_out_r         <= 1'b0;
      burn1_out_r         <= 1'b0;
    end else begin
      ext_read_block_r    <= code_protect_bit_r && ext_read_req;
      page0_write_block_r <= code_protect_bit_r && page0_write_req;
      debug_port_off_r    <= mode1_fuse_state;
      debug_port_block_r  <= mode1_fuse_state ||
                             (code_protect_bit_r && debug_req && !debug_bulk_erase);
      mode0_code_protect_bit_r      <= code_protect_bit_r && mode0_fuse_state;
      burn0_out_r         <= burn0;
      burn1_out_r         <= burn1;
    end
  end

  // Read data: write-only bits read as zero.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_data_r <= `SFFC_RESET_BYTE;
    end else if (flash_ctl_rd) begin
      rd_data_r <= `SFFC_RESET_BYTE;
      rd_data_r[`SFFC_BIT_PWE]     <= program_write_enable_r;
      rd_data_r[`SFFC_BIT_PROTECT] <= code_protect_bit_r;
    end else if (sec_rd) begin
      rd_data_r <= `SFFC_RESET_BYTE;
      rd_data_r[`SFFC_BIT_PIN]   <= sec_pin;
      rd_data_r[`SFFC_BIT_FUSE1] <= mode1_fuse_state;
      rd_data_r[`SFFC_BIT_FUSE0] <= mode0_fuse_state;
    end else if (sfr_rd || xsfr_rd) begin
      rd_data_r <= `SFFC_UNDEF_BYTE;
    end
  end
endmodule // sffc_top

// >>> tb/sffc_chk_sva.sv
// Concurrent port checks for the security fuse and flash control block.
`timescale 1ns/10ps
module sffc_chk (
  input logic        ref_clk,
  input logic        rst_b,
  input logic        sfr_wr,
  input logic [7:0]  sfr_addr,
  input logic        xsfr_wr,
  input logic        xsfr_rd,
  input logic [15:0] xsfr_addr,
  input logic [7:0]  wr_data,
  input logic        int_enabled,
  input logic        flash_byte_written,
  input logic        mass_erase_done,
  input logic        sec_pin,
  input logic        ext_read_req,
  input logic [7:0]  rd_data_r,
  input logic        program_write_enable_r,
  input logic        mass_erase_enable_r,
  input logic        code_protect_bit_r,
  input logic        ext_read_block_r,
  input logic        burn0_out_r,
  input logic        burn1_out_r
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire fc_wr = sfr_wr && sfr_addr == 8'hb2;
  property p_one_fuse; !(burn0_out_r && burn1_out_r); endproperty
  a_one_fuse: assert property (p_one_fuse) else $error("both burn outputs high");
  property p_stop;
    xsfr_wr && xsfr_addr == 16'hffd1 && wr_data != 8'ha6 |-> ##[1:3] !(burn0_out_r || burn1_out_r);
  endproperty
  a_stop: assert property (p_stop) else $error("burn not stopped");
  property p_pwe_set;
    fc_wr && wr_data[0] && !int_enabled && !flash_byte_written |-> ##[1:2] program_write_enable_r;
  endproperty
  a_pwe_set: assert property (p_pwe_set) else $error("write enable not set");
  property p_pwe_clr;
    flash_byte_written && !sfr_wr && !$past(sfr_wr) |-> ##[1:2] !program_write_enable_r;
  endproperty
  a_pwe_clr: assert property (p_pwe_clr) else $error("write enable not cleared");
  property p_pwe_lock;
    fc_wr && int_enabled && !flash_byte_written |=> $stable(program_write_enable_r) [*2];
  endproperty
  a_pwe_lock: assert property (p_pwe_lock) else $error("write enable changed");
  property p_mee_clr;
    mass_erase_done && !sfr_wr && !$past(sfr_wr) |-> ##[1:2] !mass_erase_enable_r;
  endproperty
  a_mee_clr: assert property (p_mee_clr) else $error("mass erase not cleared");
  property p_prot_set; fc_wr && wr_data[6] |-> ##[1:2] code_protect_bit_r; endproperty
  a_prot_set: assert property (p_prot_set) else $error("protect not set");
  property p_prot_hold; code_protect_bit_r |=> code_protect_bit_r; endproperty
  a_prot_hold: assert property (p_prot_hold) else $error("protect cleared");
  property p_rd_block; ext_read_req && code_protect_bit_r |=> ext_read_block_r; endproperty
  a_rd_block: assert property (p_rd_block) else $error("read not blocked");
  property p_pin; xsfr_rd && xsfr_addr == 16'hffd7 |=> rd_data_r[5] == $past(sec_pin); endproperty
  a_pin: assert property (p_pin) else $error("pin bit wrong");
endmodule // sffc_chk
bind sffc_top sffc_chk sffc_chk_i (.*);

// >>> tb/sffc_top_tb.sv
// Directed register-level test of the security fuse and flash control block.
`timescale 1ns/10ps
module sffc_top_tb;
  logic        ref_clk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic        xsfr_wr = 1'b0, xsfr_rd = 1'b0, int_enabled = 1'b0, sec_pin = 1'b0;
  logic        flash_byte_written = 1'b0, mass_erase_done = 1'b0, ext_read_req = 1'b0;
  logic        page0_write_req = 1'b0, debug_req = 1'b0, debug_bulk_erase = 1'b0;
  logic [15:0] ad = 16'h0000;
  logic [7:0]  wr_data = 8'h00, rd_data_r;
  logic        program_write_enable_r, mass_erase_enable_r, code_protect_bit_r;
  logic        ext_read_block_r, page0_write_block_r, debug_port_block_r;
  logic        debug_port_off_r, mode0_code_protect_bit_r, burn0_out_r, burn1_out_r;
  int          n_mismatch = 0, n_tests = 0;
  // Packing eight of the status outputs lets one compare cover them at once; page0_write_block_r and debug_port_block_r are not in st.
  wire [7:0]   st = {burn1_out_r, burn0_out_r, mode0_code_protect_bit_r, debug_port_off_r,
                     ext_read_block_r, code_protect_bit_r, mass_erase_enable_r,
                     program_write_enable_r};
  sffc_top #(.BURN_CYCLES(20)) sffc_top_i (.sfr_addr(ad[7:0]), .xsfr_addr(ad), .*);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic x, input logic [15:0] a, input logic [7:0] d);
    ad = a;
    wr_data = d;
    xsfr_wr = x;
    sfr_wr = !x;
    tick(1);
    xsfr_wr = 1'b0;
    sfr_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic x, input logic [15:0] a, input logic [7:0] e, input string nm);
    ad = a;
    xsfr_rd = x;
    sfr_rd = !x;
    tick(1);
    xsfr_rd = 1'b0;
    sfr_rd = 1'b0;
    tick(1);
    chk(nm, rd_data_r, e);
  endtask
  // Full burn sequence; the wait outlasts the shortened burn count.
  task automatic burn(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] e);
    wr(1'b1, 16'hffd7, 8'h80);
    wr(1'b1, 16'hffd2, c1);
    wr(1'b1, 16'hffd2, c2);
    wr(1'b1, 16'hffd1, 8'ha6);
    tick(2);
    chk("burn level", st, e);
    tick(25);
    wr(1'b1, 16'hffd1, 8'h00);
    tick(2);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    final_report;
  end
  initial begin
    tick(20);
    rst_b = 1'b1;
    rd(1'b0, 16'h00b2, 8'h00, "flash ctl reset");
    rd(1'b1, 16'hffd7, 8'h00, "pin low");
    sec_pin = 1'b1;
    rd(1'b1, 16'hffd7, 8'h20, "pin high");
    int_enabled = 1'b1;
    wr(1'b0, 16'h00b2, 8'h01);
    chk("pwe locked", st, 8'h00);
    int_enabled = 1'b0;
    wr(1'b0, 16'h00b2, 8'h03);
    chk("pwe mee set", st, 8'h03);
    flash_byte_written = 1'b1;
    mass_erase_done = 1'b1;
    tick(1);
    flash_byte_written = 1'b0;
    mass_erase_done = 1'b0;
    tick(1);
    chk("self clear", st, 8'h00);
    wr(1'b0, 16'h00b2, 8'h40);
    wr(1'b0, 16'h00b2, 8'h00);
    ext_read_req = 1'b1;
    tick(2);
    chk("protect", st, 8'h0c);
    page0_write_req = 1'b1;
    debug_req = 1'b1;
    tick(2);
    chk("page0 debug block", {6'h00, page0_write_block_r, debug_port_block_r}, 8'h03);
    debug_bulk_erase = 1'b1;
    tick(2);
    chk("bulk erase allowed", {6'h00, page0_write_block_r, debug_port_block_r}, 8'h02);
    page0_write_req = 1'b0;
    debug_req = 1'b0;
    debug_bulk_erase = 1'b0;
    tick(2);
    chk("blocks idle", {6'h00, page0_write_block_r, debug_port_block_r}, 8'h00);
    rd(1'b0, 16'h00b2, 8'h40, "flash ctl");
    rd(1'b0, 16'h0080, 8'h00, "unmapped");
    wr(1'b1, 16'hffd1, 8'ha6);
    tick(2);
    chk("unarmed", st, 8'h0c);
    burn(8'h55, 8'h82, 8'h0c);
    burn(8'h54, 8'h81, 8'h4c);
    chk("mode0 done", st, 8'h2c);
    rd(1'b1, 16'hffd7, 8'h21, "fuse0");
    burn(8'h54, 8'h82, 8'hac);
    chk("mode1 done", st, 8'h3c);
    chk("debug port blocked", {7'h00, debug_port_block_r}, 8'h01);
    rd(1'b1, 16'hffd7, 8'h23, "fuse1");
    final_report;
  end
endmodule // sffc_top_tb
